// ==== include/sdb_defs.svh ====
// Purpose: Shared constants for the burst-of-four DDR SRAM pin interface.
// Assumes: Included by bare name; guarded against double inclusion.
// Notes: Timing counts are in link-clock (K) cycles unless named otherwise.
//
// Notes on behaviour
// - Address/control on K rise; data both edges
// - Echo clocks always toggle, matched to data
// - DLL disable low bypasses, clears lock
// - DLL disable high locks after lock time
// - DLL off gives one-cycle read latency
// - Read-valid high with data, echo aligned
// - Address sampled on K rise, load only
// - Narrow uses lines 0-17, wide 0-35
// - Reads drive bus synced to echo edges
// - Load low: select high read, low write
// - Four beats; read beat0 two cycles later when locked
// - Byte enable low writes byte of beat
// - Load high is no-op, keeps burst going
`ifndef SDB_DEFS_SVH
`define SDB_DEFS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SDB_ADDR_W 18
`define SDB_DATA_W 36
`define SDB_BYTE_W 9
`define SDB_BYTES 4
`define SDB_NARROW_BYTES 2

// ----------------------------------------------------------------
// Timing counts and reset values
// ----------------------------------------------------------------
`define SDB_RD_LAT_DLL 2
`define SDB_RD_LAT_BYPASS 1
`define SDB_LOCK_K_CYCLES 2048
`define SDB_LOCK_CNT_W 16
`define SDB_BEATS 4
`define SDB_DQ_RESET 36'h000000000

`endif

// ==== include/sdb_pkg.sv ====
// Purpose: Types for the burst-of-four DDR SRAM pin interface.
// Assumes: sdb_defs.svh supplies the widths.
// Notes: Pin samples and module state travel as packed structs.
`include "sdb_defs.svh"

package sdb_pkg;

	// ----------------------------------------------------------------
	// Delay-locked loop states, Gray coded along bypass-locking-locked
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		SDB_DLL_BYPASS = 2'h0,
		SDB_DLL_LOCKING = 2'h1,
		SDB_DLL_LOCKED = 2'h3
	} sdb_dll_e;

	// One sample of every input pin from outside the core clock domain
	typedef struct packed
	{
		logic kTrue;
		logic kComp;
		logic loadStrobeN;
		logic rwSelect;
		logic [`SDB_ADDR_W-1:0] addressInputs;
		logic [`SDB_DATA_W-1:0] dataBusLines;
		logic [`SDB_BYTES-1:0] byteWriteEnableN;
		logic dllDisableN;
	} sdb_pins_s;

	// Whole state of the pin interface
	typedef struct packed
	{
		sdb_pins_s s1;
		sdb_pins_s s2;
		logic kTruePrev;
		logic kCompPrev;
		sdb_dll_e dll;
		logic [`SDB_LOCK_CNT_W-1:0] lockCnt;
		logic rdPipe0V;
		logic [`SDB_ADDR_W-1:0] rdPipe0A;
		logic rdPipe1V;
		logic [`SDB_ADDR_W-1:0] rdPipe1A;
		logic rdActive;
		logic [1:0] rdBeat;
		logic [`SDB_ADDR_W-1:0] rdAddr;
		logic wrPend;
		logic [`SDB_ADDR_W-1:0] wrPendA;
		logic wrActive;
		logic [1:0] wrBeat;
		logic [`SDB_ADDR_W-1:0] wrAddr;
		logic [`SDB_DATA_W-1:0] dqOut;
		logic dqDrive;
		logic echoTrue;
		logic echoComp;
		logic readValid;
	} sdb_state_s;

endpackage

// ==== verilog/sdb_sram_pins.sv ====
// Purpose: Device-side pin logic of a common-I/O DDR SRAM, burst of four.
// Assumes: K and K# are slow pins sampled by core_clk; all pins pass two flops.
// Notes: The array is held here; writes land at once, so reads stay coherent.
`timescale 1ns/1ps
`include "sdb_defs.svh"

module sdb_sram_pins
	import sdb_pkg::*;
#(
	parameter bit WIDE_CFG = 1'b1,
	parameter int LOCK_K_CYCLES = `SDB_LOCK_K_CYCLES
)
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic kTrue,
	input wire logic kComp,
	input wire logic loadStrobeN,
	input wire logic rwSelect,
	input wire logic [`SDB_ADDR_W-1:0] addressInputs,
	input wire logic [`SDB_DATA_W-1:0] dataBusIn,
	output logic [`SDB_DATA_W-1:0] dataBusOut,
	output logic [`SDB_DATA_W-1:0] dataBusOeN,
	input wire logic [`SDB_BYTES-1:0] byteWriteEnableN,
	input wire logic dllDisableN,
	output logic echoClockTrue,
	output logic echoClockComp,
	output logic readValidFlag
);

	// ----------------------------------------------------------------
	// Storage and state
	// ----------------------------------------------------------------
	localparam int IDX_W = `SDB_ADDR_W + 2;
	localparam int DEPTH = 1 << IDX_W;
	localparam logic [`SDB_LOCK_CNT_W-1:0] LOCK_LAST = `SDB_LOCK_CNT_W'(LOCK_K_CYCLES - 1);

	logic [`SDB_DATA_W-1:0] memArray [0:DEPTH-1]; // Burst words, four per address
	sdb_state_s st_r; // Registered state
	sdb_state_s st_nxt; // Next state
	sdb_pins_s pinsNow; // Raw pin sample
	logic kRise; // Rising edge of K seen this cycle
	logic kcRise; // Rising edge of K# seen this cycle
	logic wrEn; // Write one beat this cycle
	logic [IDX_W-1:0] wrIdx; // Array index of that beat
	logic [`SDB_DATA_W-1:0] laneMask; // Data lines in use for this width
	logic [`SDB_BYTES-1:0] byteUsed; // Byte lanes in use for this width

	// Lines in use depend on the width option
	assign laneMask = WIDE_CFG ? {`SDB_DATA_W{1'b1}}
		: {{(`SDB_DATA_W/2){1'b0}}, {(`SDB_DATA_W/2){1'b1}}};
	assign byteUsed = WIDE_CFG ? {`SDB_BYTES{1'b1}}
		: {{(`SDB_BYTES-`SDB_NARROW_BYTES){1'b0}}, {`SDB_NARROW_BYTES{1'b1}}};

	// Gather the pins into one sample
	always_comb
	begin
		pinsNow.kTrue = kTrue;
		pinsNow.kComp = kComp;
		pinsNow.loadStrobeN = loadStrobeN;
		pinsNow.rwSelect = rwSelect;
		pinsNow.addressInputs = addressInputs;
		pinsNow.dataBusLines = dataBusIn;
		pinsNow.byteWriteEnableN = byteWriteEnableN;
		pinsNow.dllDisableN = dllDisableN;
	end

	// Edges come from the second sync stage only
	assign kRise = st_r.s2.kTrue & ~st_r.kTruePrev;
	assign kcRise = st_r.s2.kComp & ~st_r.kCompPrev;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		logic rdStart;
		logic [`SDB_ADDR_W-1:0] rdStartA;
		rdStart = 1'b0;
		rdStartA = '0;
		st_nxt = st_r;
		wrEn = 1'b0;
		wrIdx = '0;
		// Two-flop synchroniser, then edge history
		st_nxt.s1 = pinsNow;
		st_nxt.s2 = st_r.s1;
		st_nxt.kTruePrev = st_r.s2.kTrue;
		st_nxt.kCompPrev = st_r.s2.kComp;
		// Echo clocks follow the sampled input clocks every cycle
		st_nxt.echoTrue = st_r.s2.kTrue;
		st_nxt.echoComp = st_r.s2.kComp;

		// Delay-locked loop control
		if (!st_r.s2.dllDisableN)
		begin
			st_nxt.dll = SDB_DLL_BYPASS;
			st_nxt.lockCnt = '0;
		end
		else
		begin
			case (st_r.dll)
				SDB_DLL_BYPASS:
					st_nxt.dll = SDB_DLL_LOCKING;
				SDB_DLL_LOCKING:
				begin
					// Count K cycles until the lock time has passed
					if (kRise)
					begin
						if (st_r.lockCnt == LOCK_LAST)
							st_nxt.dll = SDB_DLL_LOCKED;
						else
							st_nxt.lockCnt = st_r.lockCnt + 1'b1;
					end
				end
				SDB_DLL_LOCKED:
					st_nxt.dll = SDB_DLL_LOCKED;
				default:
					st_nxt.dll = SDB_DLL_BYPASS;
			endcase
		end

		if (kRise)
		begin
			// Read latency: one stage when bypassed, two when locked
			if (st_r.dll == SDB_DLL_LOCKED)
			begin
				rdStart = st_r.rdPipe1V;
				rdStartA = st_r.rdPipe1A;
			end
			else
			begin
				rdStart = st_r.rdPipe0V;
				rdStartA = st_r.rdPipe0A;
			end
			// Command capture; load high is a no-op
			st_nxt.rdPipe1V = st_r.rdPipe0V;
			st_nxt.rdPipe1A = st_r.rdPipe0A;
			st_nxt.rdPipe0V = !st_r.s2.loadStrobeN && st_r.s2.rwSelect;
			st_nxt.rdPipe0A = st_r.s2.addressInputs;
			st_nxt.wrPend = !st_r.s2.loadStrobeN && !st_r.s2.rwSelect;
			if (!st_r.s2.loadStrobeN)
				st_nxt.wrPendA = st_r.s2.addressInputs;

			// Read output on K: first or third beat, else release the bus
			if (rdStart)
			begin
				st_nxt.rdActive = 1'b1;
				st_nxt.rdAddr = rdStartA;
				st_nxt.rdBeat = 2'h1;
				st_nxt.dqOut = memArray[{rdStartA, 2'h0}] & laneMask;
				st_nxt.dqDrive = 1'b1;
				st_nxt.readValid = 1'b1;
			end
			else if (st_r.rdActive && st_r.rdBeat == 2'h2)
			begin
				// Load high does not cut the running burst short
				st_nxt.rdBeat = 2'h3;
				st_nxt.dqOut = memArray[{st_r.rdAddr, 2'h2}] & laneMask;
			end
			else
			begin
				st_nxt.rdActive = 1'b0;
				st_nxt.dqDrive = 1'b0;
				st_nxt.readValid = 1'b0;
			end

			// Write beats zero and two land on K
			if (st_r.wrPend)
			begin
				st_nxt.wrActive = 1'b1;
				st_nxt.wrAddr = st_r.wrPendA;
				st_nxt.wrBeat = 2'h1;
				wrEn = 1'b1;
				wrIdx = {st_r.wrPendA, 2'h0};
			end
			else if (st_r.wrActive && st_r.wrBeat == 2'h2)
			begin
				st_nxt.wrBeat = 2'h3;
				wrEn = 1'b1;
				wrIdx = {st_r.wrAddr, 2'h2};
			end
		end
		else if (kcRise)
		begin
			// Read beats one and three on K#
			if (st_r.rdActive && st_r.rdBeat[0])
			begin
				st_nxt.rdBeat = st_r.rdBeat + 2'h1;
				st_nxt.dqOut = memArray[{st_r.rdAddr, st_r.rdBeat}] & laneMask;
			end
			// Write beats one and three on K#
			if (st_r.wrActive && st_r.wrBeat[0])
			begin
				wrEn = 1'b1;
				wrIdx = {st_r.wrAddr, st_r.wrBeat};
				st_nxt.wrBeat = st_r.wrBeat + 2'h1;
				st_nxt.wrActive = (st_r.wrBeat != 2'h3);
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			st_r <= '0;
			st_r.s1.loadStrobeN <= 1'b1;
			st_r.s2.loadStrobeN <= 1'b1;
			st_r.s1.byteWriteEnableN <= '1;
			st_r.s2.byteWriteEnableN <= '1;
			st_r.dll <= SDB_DLL_BYPASS;
			st_r.dqOut <= `SDB_DQ_RESET;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Array write, one generate lane per byte
	// ----------------------------------------------------------------
	genvar b;
	generate
		for (b = 0; b < `SDB_BYTES; b = b + 1)
		begin : gByte
			// Byte enable sampled with its own beat
			always_ff @(posedge core_clk)
			begin
				if (wrEn && byteUsed[b] && !st_r.s2.byteWriteEnableN[b])
					memArray[wrIdx][b*`SDB_BYTE_W +: `SDB_BYTE_W] <=
						st_r.s2.dataBusLines[b*`SDB_BYTE_W +: `SDB_BYTE_W];
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign dataBusOut = st_r.dqOut;
	assign dataBusOeN = ~({`SDB_DATA_W{st_r.dqDrive}} & laneMask);
	assign echoClockTrue = st_r.echoTrue;
	assign echoClockComp = st_r.echoComp;
	assign readValidFlag = st_r.readValid;

endmodule

// ==== tb/sdb_pins_props.sv ====
// Purpose: Assertions on the SRAM pin interface
// Assumes: Bound to sdb_sram_pins; pins pass two flops
// Notes: Echo outputs lag the pins by three core cycles
`timescale 1ns/1ps
`include "sdb_defs.svh"
module sdb_pins_props
	import sdb_pkg::*;
#(
	parameter bit WIDE_CFG = 1'b1,
	parameter int LOCK_K_CYCLES = 4
)
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic kTrue,
	input wire logic kComp,
	input wire logic loadStrobeN,
	input wire logic rwSelect,
	input wire logic [`SDB_ADDR_W-1:0] addressInputs,
	input wire logic [`SDB_DATA_W-1:0] dataBusIn,
	input wire logic [`SDB_DATA_W-1:0] dataBusOut,
	input wire logic [`SDB_DATA_W-1:0] dataBusOeN,
	input wire logic [`SDB_BYTES-1:0] byteWriteEnableN,
	input wire logic dllDisableN,
	input wire logic echoClockTrue,
	input wire logic echoClockComp,
	input wire logic readValidFlag
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_echoT;
		$past(rst_n, 4) |-> echoClockTrue == $past(kTrue, 3);
	endproperty
	a_echoT: assert property (p_echoT) else $error("echo true lag");
	property p_echoC;
		$past(rst_n, 4) |-> echoClockComp == $past(kComp, 3);
	endproperty
	a_echoC: assert property (p_echoC) else $error("echo comp lag");
	property p_oeOn;
		readValidFlag |-> dataBusOeN == (WIDE_CFG ? 36'h000000000 : 36'hFFFFC0000);
	endproperty
	a_oeOn: assert property (p_oeOn) else $error("bus not driven");
	property p_oeOff;
		!readValidFlag |-> dataBusOeN == 36'hFFFFFFFFF;
	endproperty
	a_oeOff: assert property (p_oeOff) else $error("bus driven idle");
	property p_validEdge;
		$rose(readValidFlag) || $fell(readValidFlag) |-> $rose(echoClockTrue);
	endproperty
	a_validEdge: assert property (p_validEdge) else $error("valid misaligned");
	property p_dataEdge;
		readValidFlag && !$stable(dataBusOut) |-> !$stable(echoClockTrue);
	endproperty
	a_dataEdge: assert property (p_dataEdge) else $error("beat off echo");
	property p_burst;
		$rose(readValidFlag) |-> readValidFlag[*8] ##[18:19] !readValidFlag;
	endproperty
	a_burst: assert property (p_burst) else $error("burst length");
	property p_lat1;
		$rose(kTrue) && !loadStrobeN && rwSelect && !dllDisableN && !$past(dllDisableN, 8)
			|-> ##[14:17] $rose(readValidFlag);
	endproperty
	a_lat1: assert property (p_lat1) else $error("bypass latency");
	c_read: cover property ($rose(readValidFlag));
	c_write: cover property ($rose(kTrue) && !loadStrobeN && !rwSelect);
	c_lock: cover property ($rose(dllDisableN));
endmodule
bind sdb_sram_pins sdb_pins_props #(.WIDE_CFG(WIDE_CFG), .LOCK_K_CYCLES(LOCK_K_CYCLES))
	sdb_pins_props_i(.core_clk, .rst_n, .kTrue, .kComp, .loadStrobeN, .rwSelect,
	.addressInputs, .dataBusIn, .dataBusOut, .dataBusOeN, .byteWriteEnableN,
	.dllDisableN, .echoClockTrue, .echoClockComp, .readValidFlag);

// ==== tb/sdb_ctrl_model.sv ====
// Purpose: Controller side: K pair and data bus wire
// Assumes: Bench supplies write beats
// Notes: A released line shows the inverse of its last level
`timescale 1ns/1ps
module sdb_ctrl_model
	import sdb_pkg::*;
(
	input wire logic core_clk,
	output logic kTrue,
	output logic kComp,
	input wire logic wrDrive,
	input wire logic [`SDB_DATA_W-1:0] wrData,
	input wire logic [`SDB_DATA_W-1:0] dataBusOut,
	input wire logic [`SDB_DATA_W-1:0] dataBusOeN,
	output logic [`SDB_DATA_W-1:0] dataBusIn
);
	logic [`SDB_DATA_W-1:0] lastBus; // Last wire level
	// K pair, 64 ns, odd phase to the core clock
	initial
	begin
		kTrue = 1'b0;
		kComp = 1'b1;
		#6.3;
		forever
		begin
			#32 kTrue = ~kTrue;
			kComp = ~kTrue;
		end
	end
	// Wire level from both parties
	always_comb
		for (int i = 0; i < `SDB_DATA_W; i++)
			dataBusIn[i] = !dataBusOeN[i] ? dataBusOut[i] : wrDrive ? wrData[i] : ~lastBus[i];
	always_ff @(posedge core_clk)
		lastBus <= dataBusIn;
endmodule

// ==== tb/tb_sdb_sram_pins.sv ====
// Purpose: Bench for the SRAM pin interface
// Assumes: Wide build, lock count of four
// Notes: Words are pat(address, beat, pass)
`timescale 1ns/1ps
`include "sdb_defs.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin nFail++; \
	$display("BAD %s exp=%h got=%h", nm, e, g); end end
module tb_sdb_sram_pins;
	logic core_clk, rst_n, kTrue, kComp, loadStrobeN, rwSelect, dllDisableN, wrDrive;
	logic echoClockTrue, echoClockComp, readValidFlag;
	logic [`SDB_ADDR_W-1:0] addressInputs;
	logic [`SDB_DATA_W-1:0] wrData, dataBusIn, dataBusOut, dataBusOeN;
	logic [`SDB_BYTES-1:0] byteWriteEnableN;
	logic [`SDB_DATA_W-1:0] ex [4];
	int nFail, compares;
	sdb_sram_pins #(.WIDE_CFG(1'b1), .LOCK_K_CYCLES(4)) sdb_sram_pins_i(.core_clk, .rst_n,
		.kTrue, .kComp, .loadStrobeN, .rwSelect, .addressInputs, .dataBusIn, .dataBusOut,
		.dataBusOeN, .byteWriteEnableN, .dllDisableN, .echoClockTrue, .echoClockComp,
		.readValidFlag);
	sdb_ctrl_model sdb_ctrl_model_i(.core_clk, .kTrue, .kComp, .wrDrive, .wrData,
		.dataBusOut, .dataBusOeN, .dataBusIn);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [35:0] pat(logic [17:0] a, int b, bit k);
		return {a, 2'(b), k ? 16'h5A3C : 16'hC3A5};
	endfunction
	task automatic print_verdict();
		$display("compares=%0d fails=%0d", compares, nFail);
		if (nFail == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Wait for a change of sig at the chosen edge, bounded
	task automatic edge_of(input bit ech);
		logic v0;
		int n;
		v0 = ech ? echoClockTrue : kTrue;
		n = 0;
		do
		begin
			if (ech) @(negedge core_clk);
			else @(posedge core_clk);
			n++;
		end
		while ((ech ? echoClockTrue : kTrue) === v0 && n < 30);
		if (n >= 30)
		begin
			nFail++;
			print_verdict();
		end
	endtask
	task automatic kfall();
		edge_of(0);
		if (kTrue === 1'b1) edge_of(0);
	endtask
	// Write burst; beats put up half a cycle before their edge
	task automatic wr(input logic [17:0] a, input bit k, input logic [3:0] bwn);
		kfall();
		loadStrobeN <= 1'b0;
		rwSelect <= 1'b0;
		addressInputs <= a;
		edge_of(0);
		loadStrobeN <= 1'b1;
		addressInputs <= ~a;
		for (int b = 0; b < 4; b++)
		begin
			edge_of(0);
			wrDrive <= 1'b1;
			wrData <= pat(a, b, k);
			byteWriteEnableN <= bwn;
		end
		edge_of(0);
		wrDrive <= 1'b0;
		byteWriteEnableN <= 4'hF;
	endtask
	// Read burst; NOP cycles with a stray address follow the command
	task automatic rd(input logic [17:0] a, input int lo, input int hi);
		int lat;
		kfall();
		loadStrobeN <= 1'b0;
		rwSelect <= 1'b1;
		addressInputs <= a;
		edge_of(0);
		loadStrobeN <= 1'b1;
		addressInputs <= ~a;
		lat = 0;
		do
		begin
			@(negedge core_clk);
			lat++;
		end
		while (readValidFlag !== 1'b1 && lat < 60);
		`CHK("latency", 1'b1, lat >= lo && lat <= hi)
		if (lat >= 60) print_verdict();
		for (int b = 0; b < 4; b++)
		begin
			if (b > 0) edge_of(1);
			`CHK("beat", ex[b], dataBusOut)
			`CHK("oe", 36'h000000000, dataBusOeN)
		end
		edge_of(1);
		`CHK("valid end", 1'b0, readValidFlag)
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_bypass();
		wr(18'h00123, 0, 4'h0);
		wr(18'h00123, 1, 4'h2);
		for (int b = 0; b < 4; b++)
			ex[b] = (pat(18'h00123, b, 1) & ~36'h00003FE00) | (pat(18'h00123, b, 0) & 36'h00003FE00);
		rd(18'h00123, 14, 18);
		$display("bypass test done");
	endtask
	task automatic t_locked();
		@(posedge core_clk);
		dllDisableN <= 1'b1;
		repeat (20) edge_of(0);
		wr(18'h3FFFF, 0, 4'h0);
		for (int b = 0; b < 4; b++)
			ex[b] = pat(18'h3FFFF, b, 0);
		rd(18'h3FFFF, 26, 30);
		$display("locked test done");
	endtask
	task automatic t_unlock();
		@(posedge core_clk);
		dllDisableN <= 1'b0;
		repeat (4) edge_of(0);
		rd(18'h3FFFF, 14, 18);
		$display("unlock test done");
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial
	begin
		rst_n = 1'b0;
		loadStrobeN = 1'b1;
		rwSelect = 1'b1;
		addressInputs = 18'h00000;
		wrDrive = 1'b0;
		wrData = 36'h000000000;
		byteWriteEnableN = 4'hF;
		dllDisableN = 1'b0;
		nFail = 0;
		compares = 0;
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		t_bypass();
		t_locked();
		t_unlock();
		print_verdict();
	end
endmodule
